//--- ifm_pkg.sv
// Purpose: Shared constants and types for the instruction fetch bus port
// Assumes: One clock for both ends
// Notes:   Codes and beat counts
`default_nettype none
package ifm_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 30;
    localparam int DATA_W = 64;
    localparam int WORD_W = 32;
    // ****************************************
    // Encodings and reset values
    // ****************************************
    localparam logic [1:0] SIZE_FOUR  = 2'h1;
    localparam logic [1:0] SIZE_EIGHT = 2'h2;
    localparam logic [1:0] PRIO_RESET = 2'h3;
    localparam logic [3:0] BEATS_N32_4 = 4'h4;
    localparam logic [3:0] BEATS_N32_8 = 4'h8;
    localparam logic [3:0] BEATS_N64_4 = 4'h2;
    localparam logic [3:0] BEATS_N64_8 = 4'h4;
    // Gap before a third request
    localparam logic [1:0] THIRD_GAP = 2'h2;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_GAP  = 2'b11
    } ifm_req_state_type;
    // Beats needed for one request
    function automatic logic [3:0] beats_for(input logic wide, input logic [1:0] size);
        logic [3:0] n;
        n = 4'h0;
        if (size == SIZE_FOUR)
            n = wide ? BEATS_N64_4 : BEATS_N32_4;
        else
            n = wide ? BEATS_N64_8 : BEATS_N32_8;
        return n;
    endfunction
endpackage
`default_nettype wire

//--- ifm_if.sv
// Purpose: Fetch bus wires
// Assumes: Single clock, all signals active high
// Notes:   Joined by the bench
`default_nettype none
interface ifm_if;
    import ifm_pkg::*;
    logic                fetch_request;
    logic                fetch_abort;
    logic [ADDR_W-1:0]   fetch_word_address;
    logic [1:0]          line_size;
    logic                fetch_cacheable;
    logic                fetch_user_attr;
    logic [1:0]          fetch_priority;
    logic                fetch_addr_ack;
    logic                responder_width;
    logic                read_data_ack;
    logic [DATA_W-1:0]   read_data_bus;
    logic [2:0]          transfer_word_index;
    modport master (
        output fetch_request, fetch_abort, fetch_word_address, line_size,
               fetch_cacheable, fetch_user_attr, fetch_priority,
        input  fetch_addr_ack, responder_width, read_data_ack, read_data_bus,
               transfer_word_index
    );
    modport slave (
        input  fetch_request, fetch_abort, fetch_word_address, line_size,
               fetch_cacheable, fetch_user_attr, fetch_priority,
        output fetch_addr_ack, responder_width, read_data_ack, read_data_bus,
               transfer_word_index
    );
endinterface
`default_nettype wire

//--- ifm_fifo.sv
// Purpose: Small synchronous FIFO
// Assumes: Depth a power of two
// Notes:   No bypass path
`default_nettype none
module ifm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             push;
    logic             pop;
    // ****************************************
    // Flags
    // ****************************************
    assign o_in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_r != rd_r;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_r[rd_r[AW-1:0]];
    // Storage has no reset; only pointers matter
    always_ff @(posedge i_clock)
    begin
        if (push)
            mem_r[wr_r[AW-1:0]] <= i_in_data;
    end
    // Pointers
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- ifm_master.sv
// Purpose: Instruction fetch bus master port: requests, abort, beats
// Assumes: Bus clock equals core clock
// Notes:   Received words pass a 4-word FIFO
//
// Summary of operation
// R1: Drive user attribute with request until ack
// R2: Abort only unacknowledged or being-acked request
// R3: After abort drop request one full cycle
// R4: Slave returns nothing for abort at ack
// R5: Slave finishes first, drops aborted pipelined second
// R6: Drive two-bit priority, held until ack; prio_r follows i_cfg_write even while a request waits
// R7: Priority from config field, reset highest
// R8: Slave may ack immediately, latches fields
// R9: Sample responder width only in ack cycle
// R10: Ack lasts one cycle, data follows
// R11: At most two outstanding, gap between requests
// R12: Slave serves requests strictly in order
// R13: Third request two cycles after last beat
// R14: Narrow responder: pick half by word index
// R15: Wide responder: take both words per beat
// R16: Capture data only when data ack high
// R17: One ack per beat, any gap; back-to-back wide beats lose the second beat's high word
// R18: Beat count from width and line size
// R19: Line size codes four and eight words
// R20: Slave keeps index bit zero when wide
// R21: Slave acks only live request, once
`default_nettype none
module ifm_master
    import ifm_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    ifm_if.master                      bus,
    // Fetch command from the cache side
    input  wire logic                  i_cmd_valid,
    output logic                       o_cmd_ready,
    input  wire logic [ifm_pkg::ADDR_W-1:0] i_cmd_addr,
    input  wire logic                  i_cmd_cacheable,
    input  wire logic                  i_cmd_user_attr,
    input  wire logic                  i_cmd_abort,
    input  wire logic                  i_noncache_line_size_sel,
    input  wire logic [1:0]            i_fetch_priority_field,
    input  wire logic                  i_cfg_write,
    // Received instruction words
    output logic                       o_word_valid,
    input  wire logic                  i_word_ready,
    output logic [ifm_pkg::WORD_W-1:0] o_word_data,
    output logic [1:0]                 o_outstanding
);
    import ifm_pkg::*;
    ifm_req_state_type state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [1:0]        size_r;
    logic              cache_r;
    logic              user_r;
    logic [1:0]        prio_r;
    logic [1:0]        outst_r;
    logic [3:0]        left0_r;
    logic [3:0]        left1_r;
    logic              wide0_r;
    logic              wide1_r;
    logic [1:0]        gap_r;
    logic              hi_pend_r;
    logic [WORD_W-1:0] hi_word_r;
    logic              ack_live;
    logic              beat;
    logic              last_beat;
    logic              fifo_rdy;
    logic              fifo_in_v;
    logic [WORD_W-1:0] fifo_in_d;
    logic [1:0]        line_sel;

    // ****************************************
    // Request issue
    // ****************************************
    assign line_sel = (i_cmd_cacheable || i_noncache_line_size_sel) ? SIZE_EIGHT : SIZE_FOUR; // R18 R19
    assign ack_live = bus.fetch_addr_ack && state_r == ST_REQ && !bus.fetch_abort;
    assign beat      = bus.read_data_ack && outst_r != 2'h0; // R16 R17
    assign last_beat = beat && left0_r == 4'h1;
    // Stall issue on pending half word or full FIFO
    assign o_cmd_ready = state_r == ST_IDLE && outst_r < 2'h2 && gap_r == 2'h0
                         && fifo_rdy && !hi_pend_r; // R11 R13
    assign o_outstanding = outst_r;

    // Request handshake state
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            state_r <= ST_IDLE;
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (i_cmd_valid && o_cmd_ready)
                        state_r <= ST_REQ;
                ST_REQ:
                    if (bus.fetch_addr_ack || bus.fetch_abort)
                        state_r <= ST_GAP; // R3 R10 R11
                ST_GAP:
                    state_r <= ST_IDLE; // R3 R11
            endcase
        end
    end

    // Request fields held until after ack
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            addr_r  <= '0;
            size_r  <= SIZE_EIGHT;
            cache_r <= 1'b0;
            user_r  <= 1'b0;
        end
        else if (state_r == ST_IDLE && i_cmd_valid && o_cmd_ready)
        begin
            addr_r  <= i_cmd_addr;
            size_r  <= line_sel; // R19
            cache_r <= i_cmd_cacheable;
            user_r  <= i_cmd_user_attr; // R1
        end
    end

    // Config priority field
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            prio_r <= PRIO_RESET; // R7
        else if (i_cfg_write)
            prio_r <= i_fetch_priority_field; // R7
    end

    assign bus.fetch_request      = state_r == ST_REQ;
    assign bus.fetch_word_address = addr_r;
    assign bus.line_size          = size_r;
    assign bus.fetch_cacheable    = cache_r;
    assign bus.fetch_user_attr    = user_r; // R1
    assign bus.fetch_priority     = prio_r; // R6
    // Abort only while request is up
    assign bus.fetch_abort        = state_r == ST_REQ && i_cmd_abort; // R2

    // ****************************************
    // Outstanding tracking
    // ****************************************
    // Slot 0 oldest, slot 1 pipelined
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            outst_r <= 2'h0;
            left0_r <= 4'h0;
            left1_r <= 4'h0;
            wide0_r <= 1'b0;
            wide1_r <= 1'b0;
        end
        else
        begin
            if (last_beat)
            begin
                left0_r <= left1_r;
                wide0_r <= wide1_r;
            end
            else if (beat)
                left0_r <= left0_r - 4'h1;
            if (ack_live)
            begin
                // Width is sampled only in the ack cycle
                if (outst_r == 2'h0 || (outst_r == 2'h1 && last_beat))
                begin
                    left0_r <= beats_for(bus.responder_width, size_r); // R9 R18
                    wide0_r <= bus.responder_width; // R9
                end
                else
                begin
                    left1_r <= beats_for(bus.responder_width, size_r); // R9 R18
                    wide1_r <= bus.responder_width;
                end
            end
            outst_r <= outst_r + 2'(ack_live) - 2'(last_beat); // R11
        end
    end

    // Spacing after the oldest completes
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            gap_r <= 2'h0;
        else if (last_beat)
            gap_r <= THIRD_GAP; // R13
        else if (gap_r != 2'h0)
            gap_r <= gap_r - 2'h1;
    end

    // ****************************************
    // Data capture
    // ****************************************
    // Wide beat: low word waits a cycle
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            hi_pend_r <= 1'b0;
            hi_word_r <= '0;
        end
        else if (beat && wide0_r)
        begin
            hi_pend_r <= 1'b1; // R15
            hi_word_r <= bus.read_data_bus[WORD_W-1:0];
        end
        else if (hi_pend_r && fifo_rdy)
            hi_pend_r <= 1'b0;
    end

    // Narrow: even index high half, odd low
    always_comb
    begin
        fifo_in_v = 1'b0;
        fifo_in_d = '0;
        if (hi_pend_r)
        begin
            fifo_in_v = 1'b1;
            fifo_in_d = hi_word_r;
        end
        else if (beat)
        begin
            fifo_in_v = 1'b1;
            if (wide0_r || !bus.transfer_word_index[0])
                fifo_in_d = bus.read_data_bus[DATA_W-1:WORD_W]; // R14 R15
            else
                fifo_in_d = bus.read_data_bus[WORD_W-1:0]; // R14
        end
    end

    // Beats never refused; issue stalls while the FIFO is full or a half word is pending
    ifm_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_in_valid  (fifo_in_v),
        .o_in_ready  (fifo_rdy),
        .i_in_data   (fifo_in_d),
        .o_out_valid (o_word_valid),
        .i_out_ready (i_word_ready),
        .o_out_data  (o_word_data)
    );
endmodule
`default_nettype wire

//--- ifm_slave.sv
// Purpose: Local bus slave end answering instruction fetches
// Assumes: User side supplies words in order
// Notes:   One pipelined request behind the active one
`default_nettype none
module ifm_slave
    import ifm_pkg::*;
(
    input  wire logic                       i_clock,
    input  wire logic                       i_nrst,
    ifm_if.slave                            bus,
    input  wire logic                       i_wide,
    input  wire logic                       i_ack_enable,
    output logic                            o_fetch_valid,
    output logic [ifm_pkg::ADDR_W-1:0]      o_fetch_addr,
    output logic                            o_fetch_user_attr,
    input  wire logic                       i_beat_valid,
    input  wire logic [ifm_pkg::DATA_W-1:0] i_beat_data
);
    import ifm_pkg::*;
    logic              acked_r;
    logic [1:0]        queued_r;
    logic [3:0]        left_r;
    logic [3:0]        next_n_r;
    logic [2:0]        idx_r;
    logic              wide_r;
    logic [ADDR_W-1:0] addr_r;
    logic              user_r;
    logic              do_ack;
    logic              take;
    logic              rdack_r;
    logic [DATA_W-1:0] rdata_r;
    logic [2:0]        ridx_r;

    // Ack a live request once, if room
    assign do_ack = bus.fetch_request && !acked_r && i_ack_enable
                    && queued_r < 2'h2; // R8 R21
    assign take   = do_ack && !bus.fetch_abort; // R4 R5
    assign bus.fetch_addr_ack  = do_ack;
    assign bus.responder_width = i_wide; // R9
    assign bus.read_data_ack       = rdack_r;
    assign bus.read_data_bus       = rdata_r;
    assign bus.transfer_word_index = ridx_r;
    assign o_fetch_valid     = queued_r != 2'h0;
    assign o_fetch_addr      = addr_r;
    assign o_fetch_user_attr = user_r;

    // One ack per request pulse
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            acked_r <= 1'b0;
        else
            acked_r <= do_ack; // R10 R21
    end

    // Queue; beats drain the head in order
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            queued_r <= 2'h0;
            left_r   <= 4'h0;
            next_n_r <= 4'h0;
            idx_r    <= 3'h0;
            wide_r   <= 1'b0;
            addr_r   <= '0;
            user_r   <= 1'b0;
        end
        else
        begin
            if (queued_r != 2'h0 && i_beat_valid)
            begin
                left_r <= left_r - 4'h1;
                idx_r  <= idx_r + (wide_r ? 3'h2 : 3'h1); // R20
                if (left_r == 4'h1)
                begin
                    left_r <= next_n_r; // R12
                    idx_r  <= 3'h0;
                end
            end
            if (take)
            begin
                addr_r <= bus.fetch_word_address; // R8
                user_r <= bus.fetch_user_attr;
                wide_r <= i_wide;
                if (queued_r == 2'h0)
                    left_r <= beats_for(i_wide, bus.line_size); // R18
                else
                    next_n_r <= beats_for(i_wide, bus.line_size);
            end
            queued_r <= queued_r + 2'(take)
                        - 2'(queued_r != 2'h0 && i_beat_valid && left_r == 4'h1);
        end
    end

    // One registered pulse per beat
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdack_r <= 1'b0;
            rdata_r <= '0;
            ridx_r  <= 3'h0;
        end
        else
        begin
            rdack_r <= queued_r != 2'h0 && i_beat_valid; // R17 R10
            rdata_r <= i_wide ? i_beat_data
                              : {i_beat_data[WORD_W-1:0], i_beat_data[WORD_W-1:0]}; // R14
            ridx_r  <= idx_r;
        end
    end
endmodule
`default_nettype wire

//--- ifm_checker.sv
// Purpose: Fetch bus assertions
// Assumes: One clock; reset asynchronous, active low
// Notes:   Beside the interface
`default_nettype none
module ifm_checker
    import ifm_pkg::*;
(
    input wire logic                       i_clock,
    input wire logic                       i_nrst,
    input wire logic                       fetch_request,
    input wire logic                       fetch_abort,
    input wire logic [ifm_pkg::ADDR_W-1:0] fetch_word_address,
    input wire logic [1:0]                 line_size,
    input wire logic                       fetch_cacheable,
    input wire logic                       fetch_user_attr,
    input wire logic [1:0]                 fetch_priority,
    input wire logic                       fetch_addr_ack,
    input wire logic                       responder_width,
    input wire logic                       read_data_ack,
    input wire logic [2:0]                 transfer_word_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Request and acknowledge relations
    // ****************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    // Waiting request
    sequence s_pend;
        fetch_request && !fetch_addr_ack && !fetch_abort;
    endsequence
    // Two idle cycles
    sequence s_low2;
        !fetch_request ##1 !fetch_request;
    endsequence
    property p_hold;
        s_pend |=> fetch_request && $stable({fetch_word_address, line_size,
            fetch_cacheable, fetch_user_attr, fetch_priority});
    endproperty
    property p_ack_once;
        fetch_addr_ack |=> !fetch_addr_ack && !fetch_request;
    endproperty
    property p_ack_live;
        fetch_addr_ack |-> fetch_request;
    endproperty
    property p_abort_live;
        fetch_abort |-> fetch_request;
    endproperty
    property p_abort_drop;
        fetch_request && fetch_abort |=> s_low2;
    endproperty
    property p_gap;
        $fell(fetch_request) |-> s_low2;
    endproperty
    property p_size_code;
        fetch_request |-> line_size == SIZE_FOUR || line_size == SIZE_EIGHT;
    endproperty
    property p_cache_eight;
        fetch_request && fetch_cacheable |-> line_size == SIZE_EIGHT;
    endproperty
    property p_wide_index;
        read_data_ack && responder_width |-> !transfer_word_index[0];
    endproperty
    a_hold: assert property (p_hold)
        else $error("request fields moved before ack");
    a_ack_once: assert property (p_ack_once)
        else $error("ack or request after ack cycle");
    a_ack_live: assert property (p_ack_live)
        else $error("ack without request");
    a_abort_live: assert property (p_abort_live)
        else $error("abort without request");
    a_abort_drop: assert property (p_abort_drop)
        else $error("request not dropped after abort");
    a_gap: assert property (p_gap)
        else $error("request gap too short");
    a_size_code: assert property (p_size_code)
        else $error("bad line size code");
    a_cache_eight: assert property (p_cache_eight)
        else $error("cacheable fetch not eight words");
    a_wide_index: assert property (p_wide_index)
        else $error("odd word index on wide beat");
endmodule
`default_nettype wire

//--- test_instr_fetch_bus_master_port.sv
// Purpose: Bench joining both fetch ends
// Assumes: 40 MHz clock, reset held for 12 cycles
// Notes:   Words checked in the background
`default_nettype none
module test_instr_fetch_bus_master_port;
    timeunit 1ns;
    timeprecision 1ps;
    import ifm_pkg::*;
    logic                i_clock = 1'b0;
    logic                i_nrst;
    logic                cmd_valid, cmd_ready, cmd_cache, cmd_user, cmd_abort;
    logic                nc_sel, cfg_write, word_valid, word_ready, stall_all;
    logic                wide, ack_en, fetch_valid, fetch_user, beat_valid;
    logic [ADDR_W-1:0]   cmd_addr, fetch_addr;
    logic [1:0]          prio_field, outstanding, seen_size, seen_prio;
    logic [WORD_W-1:0]   word_data;
    logic [DATA_W-1:0]   beat_data;
    logic [WORD_W-1:0]   exp_q[$];
    int                  n_errors = 0;
    int                  checks_done = 0;
    int                  cyc = 0;
    // ****************************************
    // Design ends and checker
    // ****************************************
    ifm_if bus ();
    ifm_master i_ifm_master (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus.master),
        .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_addr(cmd_addr),
        .i_cmd_cacheable(cmd_cache), .i_cmd_user_attr(cmd_user),
        .i_cmd_abort(cmd_abort), .i_noncache_line_size_sel(nc_sel),
        .i_fetch_priority_field(prio_field), .i_cfg_write(cfg_write),
        .o_word_valid(word_valid), .i_word_ready(word_ready),
        .o_word_data(word_data), .o_outstanding(outstanding));
    ifm_slave i_ifm_slave (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus.slave),
        .i_wide(wide), .i_ack_enable(ack_en), .o_fetch_valid(fetch_valid),
        .o_fetch_addr(fetch_addr), .o_fetch_user_attr(fetch_user),
        .i_beat_valid(beat_valid), .i_beat_data(beat_data));
    ifm_checker i_ifm_checker (.i_clock(i_clock), .i_nrst(i_nrst),
        .fetch_request(bus.fetch_request), .fetch_abort(bus.fetch_abort),
        .fetch_word_address(bus.fetch_word_address), .line_size(bus.line_size),
        .fetch_cacheable(bus.fetch_cacheable), .fetch_user_attr(bus.fetch_user_attr),
        .fetch_priority(bus.fetch_priority), .fetch_addr_ack(bus.fetch_addr_ack),
        .responder_width(bus.responder_width), .read_data_ack(bus.read_data_ack),
        .transfer_word_index(bus.transfer_word_index));
    // Clock, 25 ns period
    always #12.5 i_clock = ~i_clock;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Ack-cycle fields; drain with periodic stall
    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        word_ready <= !stall_all && (cyc % 5 != 4);
        if (bus.fetch_addr_ack === 1'b1)
        begin
            seen_size <= bus.line_size;
            seen_prio <= bus.fetch_priority;
        end
        if (word_valid === 1'b1 && word_ready === 1'b1)
        begin
            check(exp_q.size() > 0 && word_data === exp_q[0], "word mismatch");
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    end
    // Valid held until taken, bounded
    task automatic send_cmd(input logic [ADDR_W-1:0] a, input logic c, input logic u);
        cmd_addr  <= a;
        cmd_cache <= c;
        cmd_user  <= u;
        cmd_valid <= 1'b1;
        for (int n = 0; n < 200; n++)
        begin
            @(posedge i_clock);
            if (cmd_ready === 1'b1)
                break;
        end
        cmd_valid <= 1'b0;
    endtask
    // Beats with uneven gaps
    task automatic feed(input int n, input logic [31:0] base);
        for (int k = 0; k < n; k++)
        begin
            if (wide)
            begin
                beat_data <= {base + 2 * k, base + 2 * k + 1};
                exp_q.push_back(base + 2 * k);
                exp_q.push_back(base + 2 * k + 1);
            end
            else
            begin
                beat_data <= {~(base + k), base + k};
                exp_q.push_back(base + k);
            end
            beat_valid <= 1'b1;
            @(posedge i_clock);
            beat_valid <= 1'b0;
            repeat (1 + k % 2) @(posedge i_clock);
        end
    endtask
    task automatic wait_drain;
        for (int n = 0; n < 300 && (exp_q.size() > 0 || outstanding !== 2'h0); n++)
            @(posedge i_clock);
        repeat (2) @(posedge i_clock);
        check(exp_q.size() == 0 && word_valid === 1'b0, "words lost or extra");
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        check(bus.fetch_request === 1'b0 && outstanding === 2'h0, "idle after reset");
        check(bus.fetch_priority === PRIO_RESET, "reset priority");
        $display("test reset done");
    endtask
    // Widths, size modes, priorities
    task automatic t_lines;
        logic [1:0]        p;
        logic [ADDR_W-1:0] a;
        int                nw;
        for (int k = 0; k < 6; k++)
        begin
            p = (k == 0) ? PRIO_RESET : 2'(k);
            a = ADDR_W'(32'h100 * k + 8);
            nw = (k % 3 == 0) ? 4 : 8;
            wide <= (k >= 3);
            nc_sel <= (k % 3 == 1);
            prio_field <= p;
            cfg_write <= (k != 0);
            @(posedge i_clock);
            cfg_write <= 1'b0;
            send_cmd(a, k % 3 == 2, k[0]);
            repeat (3) @(posedge i_clock);
            check(fetch_addr === a && fetch_user === k[0], "slave latch");
            check(seen_size === (nw == 4 ? SIZE_FOUR : SIZE_EIGHT), "size");
            check(seen_prio === p, "priority");
            feed((k >= 3) ? nw / 2 : nw, 32'h1000 * k);
            wait_drain();
            $display("test lines %0d done", k);
        end
    endtask
    task automatic t_pipe;
        wide <= 1'b0;
        nc_sel <= 1'b0;
        send_cmd(30'h40, 1'b0, 1'b0);
        @(posedge i_clock);
        send_cmd(30'h80, 1'b0, 1'b1);
        repeat (3) @(posedge i_clock);
        check(outstanding === 2'h2 && cmd_ready === 1'b0, "third refused");
        feed(4, 32'ha000);
        feed(4, 32'hb000);
        wait_drain();
        $display("test pipeline done");
    endtask
    task automatic t_full;
        stall_all <= 1'b1;
        send_cmd(30'h300, 1'b0, 1'b0);
        repeat (3) @(posedge i_clock);
        feed(4, 32'hc000);
        repeat (2) @(posedge i_clock);
        check(word_valid === 1'b1 && cmd_ready === 1'b0, "full buffer refuses");
        stall_all <= 1'b0;
        wait_drain();
        $display("test full buffer done");
    endtask
    task automatic t_abort;
        ack_en <= 1'b0;
        send_cmd(30'h200, 1'b1, 1'b0);
        repeat (2) @(posedge i_clock);
        cmd_abort <= 1'b1;
        @(posedge i_clock);
        cmd_abort <= 1'b0;
        ack_en <= 1'b1;
        repeat (4) @(posedge i_clock);
        check(outstanding === 2'h0 && fetch_valid === 1'b0, "abort before ack");
        cmd_abort <= 1'b1;
        send_cmd(30'h240, 1'b1, 1'b0);
        @(posedge i_clock);
        cmd_abort <= 1'b0;
        repeat (4) @(posedge i_clock);
        check(outstanding === 2'h0 && fetch_valid === 1'b0, "abort at ack");
        $display("test abort done");
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        i_nrst = 1'b0;
        {cmd_valid, cmd_cache, cmd_user, cmd_abort, nc_sel, cfg_write} = 6'h00;
        {stall_all, wide, beat_valid} = 3'h0;
        ack_en = 1'b1;
        cmd_addr = '0;
        prio_field = PRIO_RESET;
        beat_data = '0;
        repeat (12) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        t_reset();
        t_lines();
        t_pipe();
        t_full();
        t_abort();
        print_verdict();
    end
    // About 230 cycles needed
    initial
    begin
        #500000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
